// ---- design/pm_channel_mailbox_consts.vh ----
// constants for the power-management mailbox channel pair
`ifndef PM_CHANNEL_MAILBOX_CONSTS_VH
`define PM_CHANNEL_MAILBOX_CONSTS_VH

// ************************************************************
// core-side register offsets, channel 1
// ************************************************************
`define CH1_STATUS_OFS      16'hfeac
`define CH1_DATA_OUT_OFS    16'hfeae
`define CH1_DATA_IN_OFS     16'hfeb0
`define CH1_DATA_OUT_SCI_OFS 16'hfeb2
`define CH1_DATA_OUT_SMI_OFS 16'hfeb4
`define CH1_DATA_IN_SCI_OFS 16'hfeb6

// ************************************************************
// core-side register offsets, channel 2
// ************************************************************
`define CH2_STATUS_OFS      16'hfebe
`define CH2_DATA_OUT_OFS    16'hfec0
`define CH2_DATA_OUT_SCI_OFS 16'hfec4
`define CH2_DATA_OUT_SMI_OFS 16'hfec6
`define CH2_DATA_IN_SCI_OFS 16'hfec8
`define CH2_DATA_IN_OFS     16'hfed2

// ************************************************************
// status register fields and reset values
// ************************************************************
`define ST_OUT_FULL_BIT     0
`define ST_IN_FULL_BIT      1
`define ST_GEN_FLAG_BIT     2
`define ST_CMD_IND_BIT      3
`define ST_NIBBLE_LO        4
`define ST_NIBBLE_HI        7
`define STATUS_RESET        8'h00
`define LATCH_RESET         8'h00
`define RDATA_UNMAPPED      8'h00

// ************************************************************
// host irq mode field code for level mode
// ************************************************************
`define IRQ_MODE_LEVEL      3'h0

`endif

// ---- design/pm_channel_mailbox.v ----
// two-channel power-management mailbox with host read-return fifo
`timescale 1ns/1ps
`include "pm_channel_mailbox_consts.vh"

// ************************************************************
// read-return fifo
// ************************************************************
module pm_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    // word storage, pointers and fill count
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    // honest full and empty from the word count
    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready & ce;
    assign pop = out_valid & out_ready & ce;

    // storage, written only on accepted pushes
    // a push never lands on the head word while the queue holds data
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers wrap at the depth
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// ************************************************************
// one mailbox channel
// ************************************************************
module pm_chan (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire host_wr,
    input wire host_cmd,
    input wire [7:0] host_wdata,
    input wire host_data_rd,
    input wire core_st_wr,
    input wire [7:0] core_wdata,
    input wire core_do_wr,
    input wire core_doc_wr,
    input wire core_dom_wr,
    input wire core_di_rd,
    input wire core_dic_rd,
    input wire enhanced_mode_enable,
    input wire ibf_ie,
    input wire obe_ie,
    input wire irq_hw_en,
    input wire [2:0] irq_mode,
    input wire sci_en,
    input wire smi_en,
    output wire [7:0] status,
    output reg [7:0] output_latch,
    output reg [7:0] input_latch,
    output wire core_irq_ibf,
    output wire core_irq_obe,
    output reg host_irq,
    output reg sci,
    output reg smi
);
    // status fields held as separate flops
    reg output_full_flag;
    reg input_full_flag;
    reg general_flag;
    reg command_indicator;
    reg [3:0] general_flags_nibble;
    wire any_do_wr;
    wire any_di_rd;
    wire next_output_full;
    wire next_input_full;

    // any data-out flavour, any data-in flavour
    assign any_do_wr = core_do_wr | core_doc_wr | core_dom_wr;
    assign any_di_rd = core_di_rd | core_dic_rd;

    // RULE4: output full set by any data-out write
    // RULE5: host data read clears it, a write in the same cycle wins
    assign next_output_full = any_do_wr | (output_full_flag & ~host_data_rd);
    // RULE1: host write sets input full
    // RULE3: core data-in read clears it, set wins
    assign next_input_full = host_wr | (input_full_flag & ~any_di_rd);

    // RULE15: status byte layout
    // RULE6: same layout on both sides
    // RULE17: high nibble bits 4-6 carry burst, sci and smi event meaning
    assign status = {general_flags_nibble, command_indicator, general_flag,
                     input_full_flag, output_full_flag};

    // RULE8: input-full core interrupt
    assign core_irq_ibf = ibf_ie & input_full_flag;
    // RULE9: output-empty core interrupt
    // RULE10: drops once a data-out write sets output full
    assign core_irq_obe = obe_ie & ~output_full_flag;

    // status flags and latches
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            output_full_flag <= 1'b0;
            input_full_flag <= 1'b0;
            general_flag <= 1'b0;
            command_indicator <= 1'b0;
            general_flags_nibble <= 4'h0;
            output_latch <= `LATCH_RESET;
            input_latch <= `LATCH_RESET;
        end else if (ce) begin
            // RULE20: flags update in one edge
            output_full_flag <= next_output_full;
            input_full_flag <= next_input_full;
            // RULE1: latch the host byte
            if (host_wr) begin
                input_latch <= host_wdata;
                // RULE2: record data or command address
                command_indicator <= host_cmd;
            end
            // RULE14: overwrite while full is allowed, firmware avoids it
            if (any_do_wr) begin
                output_latch <= core_wdata;
            end
            // RULE16: only flag bits are core writable
            if (core_st_wr) begin
                general_flag <= core_wdata[`ST_GEN_FLAG_BIT];
                general_flags_nibble <= core_wdata[`ST_NIBBLE_HI:`ST_NIBBLE_LO];
            end
        end
    end

    // host irq and sci/smi event outputs
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            host_irq <= 1'b0;
            sci <= 1'b0;
            smi <= 1'b0;
        end else if (ce) begin
            // RULE7: level mode follows output full, read drops it
            // RULE11: pulse mode fires on the data-out write
            // pulse width shaping is left to the host side
            if (irq_mode == `IRQ_MODE_LEVEL) begin
                host_irq <= irq_hw_en & next_output_full;
            end else begin
                host_irq <= irq_hw_en & any_do_wr;
            end
            // RULE19: enhanced mode picks event by register used
            if (enhanced_mode_enable) begin
                // RULE12: sci on data-out-with-sci write
                sci <= sci_en & (core_doc_wr | core_dic_rd);
                // RULE13: smi on data-out-with-smi write
                smi <= smi_en & core_dom_wr;
            end else begin
                // RULE11: compatible mode sends enabled sci and smi
                sci <= sci_en & any_do_wr;
                smi <= smi_en & any_do_wr;
            end
        end
    end
endmodule

// ************************************************************
// top level
// ************************************************************
// Contract
// RULE1: host write to data or command address latches byte, sets input full.
// RULE2: status bit 3 clears on data write, sets on command write.
// RULE3: core read of data-in or data-in-with-sci clears input full.
// RULE4: any core data-out write sets output full; writes to that bit ignored.
// RULE5: host data read returns output latch and clears output full.
// RULE6: host status read returns the same layout the core sees.
// RULE7: level irq mode with hardware irq on: host data read drops irq.
// RULE8: input-full core interrupt raised while full when its enable is set.
// RULE9: output-empty core interrupt high while output full is clear, if enabled.
// RULE10: plain data-out write drops the output-empty core interrupt.
// RULE11: plain data-out write sends host irq; compatible mode also sci/smi.
// RULE12: data-out-with-sci write acts as plain write plus sci if enabled.
// RULE13: data-out-with-smi write acts as plain write plus smi if enabled.
// RULE14: firmware should write output latch only while output full clear.
// RULE15: status: out full, in full, flag, command bit, four flags; reset zero.
// RULE16: core may write bits 2 and 7-4 only.
// RULE17: flags 0-2 mean burst, sci event, smi event in acpi use.
// RULE18: two independent channels, each with its own registers and latches.
// RULE19: enhanced sci/smi behaviour only when the enhanced enable is set.
// RULE20: flag updates visible to the other side on its next access.
module pm_channel_mailbox #(
    parameter FIFO_WIDTH = 8,
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
) (
    input wire CORE_CLK,
    input wire ARST_N,
    input wire CLK_EN,
    input wire [15:0] CORE_ADDR,
    input wire CORE_WR,
    input wire CORE_RD,
    input wire [7:0] CORE_WDATA,
    output reg [7:0] CORE_RDATA,
    input wire HOST_CHAN,
    input wire HOST_CMD,
    input wire HOST_WR,
    input wire [7:0] HOST_WDATA,
    input wire HOST_RD,
    output wire HOST_READY,
    output wire HOST_RVALID,
    input wire HOST_RREADY,
    output wire [FIFO_WIDTH-1:0] HOST_RDATA,
    input wire [1:0] ENH_MODE_EN,
    input wire [1:0] CORE_IBF_IE,
    input wire [1:0] CORE_OBE_IE,
    input wire [1:0] HOST_IRQ_HW_EN,
    input wire [5:0] HOST_IRQ_MODE,
    input wire [1:0] HW_SCI_EN,
    input wire [1:0] HW_SMI_EN,
    output wire [1:0] CORE_IRQ_IBF,
    output wire [1:0] CORE_IRQ_OBE,
    output wire [1:0] HOST_IRQ,
    output wire [1:0] SCI_PULSE,
    output wire [1:0] SMI_PULSE
);
    // per-channel offset tables and channel views
    wire [15:0] ofs_st [0:1];
    wire [15:0] ofs_do [0:1];
    wire [15:0] ofs_doc [0:1];
    wire [15:0] ofs_dom [0:1];
    wire [15:0] ofs_di [0:1];
    wire [15:0] ofs_dic [0:1];
    wire [7:0] status [0:1];
    wire [7:0] out_latch [0:1];
    wire [7:0] in_latch [0:1];
    wire host_rd_take;
    wire fifo_in_ready;
    wire [7:0] host_ret;
    reg [7:0] next_rdata;
    integer i;

    // one table entry per channel, decoded by exact match
    assign ofs_st[0] = `CH1_STATUS_OFS;
    assign ofs_st[1] = `CH2_STATUS_OFS;
    assign ofs_do[0] = `CH1_DATA_OUT_OFS;
    assign ofs_do[1] = `CH2_DATA_OUT_OFS;
    assign ofs_doc[0] = `CH1_DATA_OUT_SCI_OFS;
    assign ofs_doc[1] = `CH2_DATA_OUT_SCI_OFS;
    assign ofs_dom[0] = `CH1_DATA_OUT_SMI_OFS;
    assign ofs_dom[1] = `CH2_DATA_OUT_SMI_OFS;
    assign ofs_di[0] = `CH1_DATA_IN_OFS;
    assign ofs_di[1] = `CH2_DATA_IN_OFS;
    assign ofs_dic[0] = `CH1_DATA_IN_SCI_OFS;
    assign ofs_dic[1] = `CH2_DATA_IN_SCI_OFS;

    // host read taken only when the return fifo has room
    // a refused read leaves status and latches untouched
    assign HOST_READY = host_rd_take | ~HOST_RD ? 1'b1 : 1'b0;
    assign host_rd_take = HOST_RD & fifo_in_ready & CLK_EN;

    // RULE5: data read returns output latch
    // RULE6: command-address read returns status
    assign host_ret = HOST_CMD ? status[HOST_CHAN] : out_latch[HOST_CHAN];

    // RULE18: two identical channels
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_chan
            pm_chan u_chan (
                .clk(CORE_CLK),
                .arst_n(ARST_N),
                .ce(CLK_EN),
                .host_wr(HOST_WR & (HOST_CHAN == g)),
                .host_cmd(HOST_CMD),
                .host_wdata(HOST_WDATA),
                .host_data_rd(host_rd_take & ~HOST_CMD & (HOST_CHAN == g)),
                .core_st_wr(CORE_WR & (CORE_ADDR == ofs_st[g])),
                .core_wdata(CORE_WDATA),
                .core_do_wr(CORE_WR & (CORE_ADDR == ofs_do[g])),
                .core_doc_wr(CORE_WR & (CORE_ADDR == ofs_doc[g])),
                .core_dom_wr(CORE_WR & (CORE_ADDR == ofs_dom[g])),
                .core_di_rd(CORE_RD & (CORE_ADDR == ofs_di[g])),
                .core_dic_rd(CORE_RD & (CORE_ADDR == ofs_dic[g])),
                .enhanced_mode_enable(ENH_MODE_EN[g]),
                .ibf_ie(CORE_IBF_IE[g]),
                .obe_ie(CORE_OBE_IE[g]),
                .irq_hw_en(HOST_IRQ_HW_EN[g]),
                .irq_mode(HOST_IRQ_MODE[3*g+2:3*g]),
                .sci_en(HW_SCI_EN[g]),
                .smi_en(HW_SMI_EN[g]),
                .status(status[g]),
                .output_latch(out_latch[g]),
                .input_latch(in_latch[g]),
                .core_irq_ibf(CORE_IRQ_IBF[g]),
                .core_irq_obe(CORE_IRQ_OBE[g]),
                .host_irq(HOST_IRQ[g]),
                .sci(SCI_PULSE[g]),
                .smi(SMI_PULSE[g])
            );
        end
    endgenerate

    // host read answers queue here until the host drains them
    pm_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_ret_fifo (
        .clk(CORE_CLK),
        .arst_n(ARST_N),
        .ce(CLK_EN),
        .in_valid(HOST_RD),
        .in_ready(fifo_in_ready),
        .in_data(host_ret),
        .out_valid(HOST_RVALID),
        .out_ready(HOST_RREADY),
        .out_data(HOST_RDATA)
    );

    // core read mux, unmapped reads and write-only registers give zero
    // data-in reads clear input full, so the core strobe lasts one cycle
    always @* begin
        next_rdata = `RDATA_UNMAPPED;
        for (i = 0; i < 2; i = i + 1) begin
            if (CORE_ADDR == ofs_st[i]) begin
                next_rdata = status[i];
            end else if ((CORE_ADDR == ofs_di[i]) || (CORE_ADDR == ofs_dic[i])) begin
                next_rdata = in_latch[i];
            end
        end
    end

    // core read data registered one edge after the strobe
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CORE_RDATA <= `RDATA_UNMAPPED;
        end else if (CLK_EN && CORE_RD) begin
            CORE_RDATA <= next_rdata;
        end
    end
endmodule

// ---- test/pm_channel_mailbox_chk.sv ----
// assertion checker for the mailbox channel pair
`timescale 1ns/1ps
module pm_channel_mailbox_chk #(
    parameter FIFO_WIDTH = 8
) (
    input wire CORE_CLK,
    input wire ARST_N,
    input wire CLK_EN,
    input wire [15:0] CORE_ADDR,
    input wire CORE_WR,
    input wire HOST_CHAN,
    input wire HOST_CMD,
    input wire HOST_WR,
    input wire HOST_RD,
    input wire HOST_READY,
    input wire HOST_RVALID,
    input wire HOST_RREADY,
    input wire [FIFO_WIDTH-1:0] HOST_RDATA,
    input wire [1:0] ENH_MODE_EN,
    input wire [1:0] CORE_IBF_IE,
    input wire [1:0] CORE_OBE_IE,
    input wire [5:0] HOST_IRQ_MODE,
    input wire [1:0] HW_SCI_EN,
    input wire [1:0] HW_SMI_EN,
    input wire [1:0] CORE_IRQ_IBF,
    input wire [1:0] CORE_IRQ_OBE,
    input wire [1:0] HOST_IRQ,
    input wire [1:0] SCI_PULSE,
    input wire [1:0] SMI_PULSE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    // taken core write and taken host data read on channel 1
    wire cw = CLK_EN && CORE_WR;
    wire hrd = CLK_EN && HOST_RD && HOST_READY && !HOST_CHAN && !HOST_CMD;
    a_wr_sets_full: assert property (
        CLK_EN && HOST_WR && !HOST_CHAN && CORE_IBF_IE[0] |=> CORE_IRQ_IBF[0])
        else $error("input full interrupt missing after host write");
    a_ibf_gate: assert property (!CORE_IBF_IE[0] |-> !CORE_IRQ_IBF[0])
        else $error("input full interrupt while disabled");
    a_obe_gate: assert property (!CORE_OBE_IE[1] |-> !CORE_IRQ_OBE[1])
        else $error("output empty interrupt while disabled");
    a_do_drops_obe: assert property (
        cw && CORE_ADDR == 16'hfeae |=> !CORE_IRQ_OBE[0])
        else $error("output empty interrupt kept after data out write");
    a_rd_frees_out: assert property (
        hrd && !cw && CORE_OBE_IE[0] |=> CORE_IRQ_OBE[0])
        else $error("output full not cleared by host read");
    a_level_irq_drop: assert property (
        hrd && !cw && HOST_IRQ_MODE[2:0] == 3'h0 |=> ##[0:1] !HOST_IRQ[0])
        else $error("host irq still high after data read");
    a_compat_sci: assert property (
        cw && CORE_ADDR == 16'hfeae && !ENH_MODE_EN[0] && HW_SCI_EN[0] |=> SCI_PULSE[0])
        else $error("no sci after plain write in compatible mode");
    a_enh_plain_quiet: assert property (
        cw && CORE_ADDR == 16'hfeae && ENH_MODE_EN[0] |=> !SCI_PULSE[0] && !SMI_PULSE[0])
        else $error("sci or smi after plain write in enhanced mode");
    a_enh_smi: assert property (
        cw && CORE_ADDR == 16'hfeb4 && ENH_MODE_EN[0] && HW_SMI_EN[0] |=> SMI_PULSE[0])
        else $error("no smi after smi data out write");
    a_answer_stands: assert property (
        HOST_RVALID && !HOST_RREADY |=> HOST_RVALID && $stable(HOST_RDATA))
        else $error("host answer changed before it was taken");
    a_ready_idle: assert property (!HOST_RD |-> HOST_READY)
        else $error("host ready low with no read pending");
endmodule
bind pm_channel_mailbox pm_channel_mailbox_chk #(.FIFO_WIDTH(FIFO_WIDTH)) chk_u (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .CLK_EN(CLK_EN), .CORE_ADDR(CORE_ADDR),
    .CORE_WR(CORE_WR), .HOST_CHAN(HOST_CHAN), .HOST_CMD(HOST_CMD), .HOST_WR(HOST_WR),
    .HOST_RD(HOST_RD), .HOST_READY(HOST_READY), .HOST_RVALID(HOST_RVALID),
    .HOST_RREADY(HOST_RREADY), .HOST_RDATA(HOST_RDATA), .ENH_MODE_EN(ENH_MODE_EN),
    .CORE_IBF_IE(CORE_IBF_IE), .CORE_OBE_IE(CORE_OBE_IE), .HOST_IRQ_MODE(HOST_IRQ_MODE),
    .HW_SCI_EN(HW_SCI_EN), .HW_SMI_EN(HW_SMI_EN), .CORE_IRQ_IBF(CORE_IRQ_IBF),
    .CORE_IRQ_OBE(CORE_IRQ_OBE), .HOST_IRQ(HOST_IRQ), .SCI_PULSE(SCI_PULSE),
    .SMI_PULSE(SMI_PULSE)
);

// ---- test/pm_host_model.sv ----
// host processor model on the mailbox host port
`timescale 1ns/1ps
module pm_host_model (
    input wire CORE_CLK,
    input wire HOST_READY,
    input wire HOST_RVALID,
    input wire [7:0] HOST_RDATA,
    output reg HOST_CHAN,
    output reg HOST_CMD,
    output reg HOST_WR,
    output reg [7:0] HOST_WDATA,
    output reg HOST_RD,
    output reg HOST_RREADY
);
    // idle host port
    initial begin
        HOST_CHAN = 1'b0;
        HOST_CMD = 1'b0;
        HOST_WR = 1'b0;
        HOST_WDATA = 8'h00;
        HOST_RD = 1'b0;
        HOST_RREADY = 1'b0;
    end
    // one write strobe; sel is channel then command; data line inverted once released
    task host_write(input [1:0] sel, input [7:0] d);
        begin
            @(posedge CORE_CLK);
            HOST_CHAN <= sel[1];
            HOST_CMD <= sel[0];
            HOST_WDATA <= d;
            HOST_WR <= 1'b1;
            @(posedge CORE_CLK);
            HOST_WR <= 1'b0;
            HOST_WDATA <= ~d;
        end
    endtask
    // read request held until ready is seen, gives up after four edges
    task host_req(input [1:0] sel, output ok);
        integer n;
        begin
            ok = 1'b0;
            @(posedge CORE_CLK);
            HOST_CHAN <= sel[1];
            HOST_CMD <= sel[0];
            HOST_RD <= 1'b1;
            for (n = 0; n < 4 && !ok; n = n + 1) begin
                @(posedge CORE_CLK);
                ok = (HOST_READY === 1'b1);
            end
            HOST_RD <= 1'b0;
        end
    endtask
    // take one answer from the return queue
    task host_pop(output [7:0] d);
        integer n;
        begin
            d = 8'hxx;
            @(posedge CORE_CLK);
            HOST_RREADY <= 1'b1;
            for (n = 0; n < 8; n = n + 1) begin
                @(posedge CORE_CLK);
                if (HOST_RVALID === 1'b1) begin
                    d = HOST_RDATA;
                    n = 8;
                end
            end
            HOST_RREADY <= 1'b0;
        end
    endtask
    // complete read: request then answer
    task host_read(input [1:0] sel, output [7:0] d);
        reg ok;
        begin
            host_req(sel, ok);
            host_pop(d);
        end
    endtask
endmodule

// ---- test/pm_channel_mailbox_test.sv ----
// self-checking bench for the mailbox channel pair
`timescale 1ns/1ps
module pm_channel_mailbox_test;
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    reg [15:0] addr = 16'h0000;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg [7:0] wdata = 8'h00;
    reg [1:0] enh = 2'b00;
    reg [1:0] ibf_ie = 2'b00;
    reg [1:0] obe_ie = 2'b00;
    reg [5:0] hmode = 6'h00;
    wire [7:0] rdata;
    wire h_chan, h_cmd, h_wr, h_rd, h_ready, h_rvalid, h_rready;
    wire [7:0] h_wdata, h_rdata;
    wire [1:0] irq_ibf, irq_obe, host_irq, sci, smi;
    integer num_errors = 0;
    integer tests_run = 0;
    integer cycles = 0;
    integer i;
    reg ok;
    reg [7:0] d;
    // data-out address and expected sci/smi per step, step 0 in the low bits
    reg [63:0] do_tab = 64'hfeb4_feb2_feae_feae;
    reg [7:0] pul_tab = 8'h63;

    pm_channel_mailbox dut_u (
        .CORE_CLK(clk), .ARST_N(arst_n), .CLK_EN(1'b1), .CORE_ADDR(addr), .CORE_WR(wr),
        .CORE_RD(rd), .CORE_WDATA(wdata), .CORE_RDATA(rdata), .HOST_CHAN(h_chan),
        .HOST_CMD(h_cmd), .HOST_WR(h_wr), .HOST_WDATA(h_wdata), .HOST_RD(h_rd),
        .HOST_READY(h_ready), .HOST_RVALID(h_rvalid), .HOST_RREADY(h_rready),
        .HOST_RDATA(h_rdata), .ENH_MODE_EN(enh), .CORE_IBF_IE(ibf_ie), .CORE_OBE_IE(obe_ie),
        .HOST_IRQ_HW_EN(2'b11), .HOST_IRQ_MODE(hmode), .HW_SCI_EN(2'b11), .HW_SMI_EN(2'b11),
        .CORE_IRQ_IBF(irq_ibf), .CORE_IRQ_OBE(irq_obe), .HOST_IRQ(host_irq),
        .SCI_PULSE(sci), .SMI_PULSE(smi)
    );
    pm_host_model host_u (
        .CORE_CLK(clk), .HOST_READY(h_ready), .HOST_RVALID(h_rvalid), .HOST_RDATA(h_rdata),
        .HOST_CHAN(h_chan), .HOST_CMD(h_cmd), .HOST_WR(h_wr), .HOST_WDATA(h_wdata),
        .HOST_RD(h_rd), .HOST_RREADY(h_rready)
    );

    // ********
    // clock, timeout, helpers
    // ********
    always #4 clk = ~clk;
    // cut a hang short
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            num_errors = num_errors + 1;
            end_sim;
        end
    end
    task chk(input [8*8-1:0] name, input [7:0] exp, input [7:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("ERROR %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task core_wr(input [15:0] a, input [7:0] v);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= v;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
            #1;
        end
    endtask
    task core_rd(input [15:0] a, output [7:0] v);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1;
            v = rdata;
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d errors %0d", tests_run, num_errors);
            if (num_errors == 0 && tests_run > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask

    // ********
    // test sequence
    // ********
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        core_rd(16'hfeac, d);
        chk("st1", 8'h00, d);
        core_rd(16'hfebe, d);
        chk("st2", 8'h00, d);
        host_u.host_write(2'b00, 8'ha5);
        core_rd(16'hfeac, d);
        chk("st1", 8'h02, d);
        @(posedge clk);
        ibf_ie <= 2'b11;
        host_u.host_write(2'b01, 8'h3c);
        #1;
        chk("ibf_irq", 8'h01, {7'h0, irq_ibf[0]});
        core_rd(16'hfeac, d);
        chk("st1", 8'h0a, d);
        core_rd(16'hfeb6, d);
        chk("din", 8'h3c, d);
        core_rd(16'hfeac, d);
        chk("st1", 8'h08, d);
        core_wr(16'hfeac, 8'hff);
        host_u.host_read(2'b01, d);
        chk("hst1", 8'hfc, d);
        core_wr(16'hfeac, 8'h00);
        @(posedge clk);
        obe_ie <= 2'b01;
        // plain data-out write in compatible mode, then each flavour in enhanced; latch written only while empty
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge clk);
            enh <= {1'b0, i > 0};
            core_wr(do_tab[16*i +: 16], 8'h50 + i[7:0]);
            chk("pulse", {6'h0, pul_tab[2*i +: 2]}, {6'h0, sci[0], smi[0]});
            chk("obe_irq", 8'h00, {7'h0, irq_obe[0]});
            @(posedge clk);
            #1;
            chk("hirq", 8'h01, {7'h0, host_irq[0]});
            host_u.host_read(2'b00, d);
            chk("hdata", 8'h50 + i[7:0], d);
            @(posedge clk);
            #1;
            chk("hirq", 8'h00, {7'h0, host_irq[0]});
            core_rd(16'hfeac, d);
            chk("st1", 8'h08, d);
        end
        host_u.host_write(2'b10, 8'h77);
        #1;
        chk("ibf2", 8'h01, {7'h0, irq_ibf[1]});
        core_rd(16'hfeac, d);
        chk("st1", 8'h08, d);
        core_rd(16'hfed2, d);
        chk("din2", 8'h77, d);
        // channel 2 host irq in pulse mode: one cycle high, then low
        @(posedge clk);
        hmode <= 6'h08;
        core_wr(16'hfec4, 8'h99);
        chk("ch2evt", 8'h07, {5'h0, host_irq[1], sci[1], smi[1]});
        @(posedge clk);
        #1;
        chk("hirq2", 8'h00, {7'h0, host_irq[1]});
        host_u.host_read(2'b11, d);
        chk("hst2", 8'h01, d);
        host_u.host_read(2'b10, d);
        chk("hdata2", 8'h99, d);
        // fill the answer queue until refused, then drain it
        for (i = 0; i < 9; i = i + 1) begin
            host_u.host_req(2'b01, ok);
            chk("ready", {7'h0, i < 8}, {7'h0, ok});
        end
        for (i = 0; i < 8; i = i + 1) begin
            host_u.host_pop(d);
            chk("fifo", 8'h08, d);
        end
        #1;
        chk("rvalid", 8'h00, {7'h0, h_rvalid});
        end_sim;
    end
endmodule
